// *** hdl/tcf_defs.vh ***
// Purpose: constants for the compare force, master compare and counter block
// Assumes: word-aligned AHB-Lite register map, byte data in bits 7:0
// Notes: printed offsets are indexes; byte address is four times the index
`ifndef TCF_DEFS_VH
`define TCF_DEFS_VH
`define TCF_IDX_SELECT 8'h00
`define TCF_IDX_FORCE 8'h01
`define TCF_IDX_MMASK 8'h02
`define TCF_IDX_MDATA 8'h03
`define TCF_IDX_CNTH 8'h04
`define TCF_IDX_CNTL 8'h05
`define TCF_IDX_CTRL 8'h06
`define TCF_IDX_TOV 8'h07
`define TCF_IDX_ACTH 8'h08
`define TCF_IDX_ACTL 8'h09
`define TCF_IDX_DISC 8'h2c
`define TCF_IDX_CMPV 8'h30
`define TCF_IDX_IRQ_STAT 8'h40
`define TCF_IDX_IRQ_MASK 8'h41
`define TCF_IDX_PRESC 8'h42
`define TCF_CTRL_EN 7
`define TCF_CTRL_TEST 0
`define TCF_IRQ_CMP 7:0
`define TCF_IRQ_OVF 8
`define TCF_RST_BYTE 8'h00
`define TCF_RST_CNT 16'h0000
`define TCF_RST_PRESC 8'h00
`endif

// *** hdl/tcf_prescaler.v ***
// Purpose: divides hclk into one-cycle count ticks
// Assumes: divide ratio is value plus one
// Notes: not resynchronised by counter writes
`timescale 1ns/1ns
`include "tcf_defs.vh"
module tcf_prescaler
(
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // control
   input wire enable,
   input wire [7:0] ratio,
   // tick out
   output reg tick
);
   reg [7:0] div_r;
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         div_r <= 8'h00;
         tick <= 1'b0;
      end
      else if (!enable)
      begin
         div_r <= 8'h00;
         tick <= 1'b0;
      end
      else if (div_r >= ratio)
      begin
         div_r <= 8'h00;
         tick <= 1'b1;
      end
      else
      begin
         div_r <= div_r + 8'h01;
         tick <= 1'b0;
      end
   end
endmodule // tcf_prescaler

// *** hdl/tcf_pin_logic.v ***
// Purpose: output-compare pin actions for eight channels
// Assumes: action code per channel 00 none, 01 toggle, 10 clear, 11 set
// Notes: channel 7 master data overrides channels 6:0
`timescale 1ns/1ns
module tcf_pin_logic
(
   // current pins
   input wire [7:0] pins,
   // triggers and configuration
   input wire [7:0] fire,
   input wire [15:0] action,
   input wire ch7_event,
   input wire [7:0] master_mask,
   input wire [7:0] master_data,
   input wire [7:0] select,
   input wire [7:0] disconnect,
   // next pin values
   output reg [7:0] pins_nxt
);
   integer i;
   always @*
   begin
      pins_nxt = pins;
      for (i = 0; i < 8; i = i + 1)
      begin
         if (fire[i] && select[i] && !disconnect[i]) // RL12 RL14
         begin
            case (action[2*i +: 2])
               2'b01: pins_nxt[i] = ~pins[i];
               2'b10: pins_nxt[i] = 1'b0;
               2'b11: pins_nxt[i] = 1'b1;
               default: pins_nxt[i] = pins[i];
            endcase
         end
         if (ch7_event && master_mask[i] && select[i] && !disconnect[i])
            pins_nxt[i] = master_data[i]; // RL4 RL6 RL7
      end
   end
endmodule // tcf_pin_logic

// *** hdl/tcf_timer.v ***
// Purpose: compare force, master compare and 16-bit main counter
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes: registers sit in bits 7:0 of word at four times the index; compare values take bits 15:0, irq registers 8:0
// How it works
// RL1: compare force register always reads zero; written ones act one cycle.
// RL2: a force bit runs the channel pin action without setting its flag.
// RL3: force and real match together: force action, flag stays clear.
// RL4: channel 7 event beats channels 6 to 0 on pins it affects.
// RL5: channel 7 event is channel 7 match or overflow with toggle bit 7; code also raises it on force bit 7.
// RL6: on channel 7 event masked pins take master data bits.
// RL7: transfer only when channel is output compare and not disconnected.
// RL8: the main counter is sixteen bits and counts up.
// RL9: word read returns both counter bytes from one sample; code returns one counter byte per read, CNTH and CNTL at separate indexes.
// RL10: counter writes ignored unless test mode is set.
// RL11: first period after counter write may be short; no resync.
// RL12: select bit zero means input capture, one means output compare.
// RL13: counter steps on each tick when enabled, wraps, flags overflow.
// RL14: several force bits in one write all act in the same cycle.
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ns
`include "tcf_defs.vh"
module tcf_timer
(
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // ahb-lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // compare pins
   output reg [7:0] compare_pins,
   output reg [7:0] compare_pins_oe,
   // interrupt
   output reg irq
);
   reg [7:0] capture_compare_select_r;
   reg [7:0] master_compare_mask_r;
   reg [7:0] master_compare_data_r;
   reg [7:0] ctrl_r;
   reg [7:0] toggle_on_overflow_r;
   reg [15:0] action_r;
   reg [7:0] output_pin_disconnect_r;
   reg [15:0] channel_compare_value_r [0:7];
   reg [8:0] irq_stat_r;
   reg [8:0] irq_mask_r;
   reg [7:0] presc_r;
   reg [15:0] main_counter_r;
   reg [7:0] force_bit_r;
   reg [7:0] ap_idx_r;
   reg ap_wr_r;
   reg ap_valid_r;
   reg ap_bad_r;
   reg [7:0] rd_byte;
   reg [15:0] cnt_nxt;
   reg [8:0] stat_nxt;
   reg [7:0] match;
   reg [7:0] fire;
   reg ovf;
   reg ch7_event;
   wire tick;
   wire [7:0] pins_nxt;
   wire [7:0] wb;
   wire wr_en;
   wire wr_ok;
   wire [7:0] rd_idx;
   integer k;
   integer j;

   // word index of a byte address; misaligned gives all ones
   function [7:0] reg_index;
      input [31:0] a;
      begin
         if (a[1:0] != 2'b00 || a[31:10] != 22'h000000)
            reg_index = 8'hff;
         else
            reg_index = a[9:2];
      end
   endfunction

   // a good word write to the given register is in its data phase
   function wr_hit;
      input ok;
      input [7:0] cur;
      input [7:0] idx;
      begin
         wr_hit = ok && cur == idx;
      end
   endfunction

   // register index falls in the compare value block
   function is_cmpv;
      input [7:0] idx;
      begin
         is_cmpv = idx >= `TCF_IDX_CMPV && idx < `TCF_IDX_CMPV + 8'h08;
      end
   endfunction

   assign wb = hwdata[7:0];
   assign wr_en = ap_valid_r && ap_wr_r;
   assign wr_ok = wr_en && !ap_bad_r;
   assign rd_idx = reg_index(haddr);

   tcf_prescaler u_presc
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .enable(ctrl_r[`TCF_CTRL_EN]),
      .ratio(presc_r),
      .tick(tick)
   );

   tcf_pin_logic u_pins
   (
      .pins(compare_pins),
      .fire(fire),
      .action(action_r),
      .ch7_event(ch7_event),
      .master_mask(master_compare_mask_r),
      .master_data(master_compare_data_r),
      .select(capture_compare_select_r),
      .disconnect(output_pin_disconnect_r),
      .pins_nxt(pins_nxt)
   );

   // counter, matches and events
   always @*
   begin
      ovf = 1'b0;
      cnt_nxt = main_counter_r;
      if (ctrl_r[`TCF_CTRL_EN] && tick)
      begin
         cnt_nxt = main_counter_r + 16'h0001; // RL8 RL13
         ovf = (main_counter_r == 16'hffff); // RL13
      end
      for (k = 0; k < 8; k = k + 1)
         match[k] = ctrl_r[`TCF_CTRL_EN] && tick &&
            capture_compare_select_r[k] &&
            channel_compare_value_r[k] == cnt_nxt;
      fire = match | force_bit_r; // RL2 RL14
      ch7_event = (match[7] || force_bit_r[7]) ||
         (ovf && toggle_on_overflow_r[7]); // RL5
      stat_nxt = irq_stat_r | {ovf, match & ~force_bit_r}; // RL3
      if (wr_hit(wr_ok, ap_idx_r, `TCF_IDX_IRQ_STAT))
         stat_nxt = (irq_stat_r & ~{hwdata[8], wb}) |
            {ovf, match & ~force_bit_r};
   end

   // read mux, indexed by the address phase
   always @*
   begin
      case (rd_idx)
         `TCF_IDX_SELECT: rd_byte = capture_compare_select_r;
         `TCF_IDX_FORCE: rd_byte = 8'h00; // RL1
         `TCF_IDX_MMASK: rd_byte = master_compare_mask_r;
         `TCF_IDX_MDATA: rd_byte = master_compare_data_r;
         `TCF_IDX_CNTH: rd_byte = main_counter_r[15:8];
         `TCF_IDX_CNTL: rd_byte = main_counter_r[7:0];
         `TCF_IDX_CTRL: rd_byte = ctrl_r;
         `TCF_IDX_TOV: rd_byte = toggle_on_overflow_r;
         `TCF_IDX_ACTH: rd_byte = action_r[15:8];
         `TCF_IDX_ACTL: rd_byte = action_r[7:0];
         `TCF_IDX_DISC: rd_byte = output_pin_disconnect_r;
         `TCF_IDX_IRQ_STAT: rd_byte = irq_stat_r[7:0];
         `TCF_IDX_IRQ_MASK: rd_byte = irq_mask_r[7:0];
         `TCF_IDX_PRESC: rd_byte = presc_r;
         default:
            if (is_cmpv(rd_idx))
               rd_byte = channel_compare_value_r[rd_idx[2:0]][7:0];
            else
               rd_byte = 8'h00;
      endcase
   end

   // bus front end: address phase capture and read snapshot
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ap_idx_r <= 8'hff;
         ap_wr_r <= 1'b0;
         ap_valid_r <= 1'b0;
         ap_bad_r <= 1'b0;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         if (hready)
         begin
            ap_valid_r <= hsel && htrans[1];
            ap_wr_r <= hwrite;
            ap_idx_r <= rd_idx;
            ap_bad_r <= hsize != 3'b010;
         end
         // read data is sampled in the address phase: one snapshot per word
         if (hready && hsel && htrans[1] && !hwrite)
            hrdata <= {24'h000000, rd_byte}; // RL1 RL9
         else
            hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // software configuration registers
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         capture_compare_select_r <= `TCF_RST_BYTE;
         master_compare_mask_r <= `TCF_RST_BYTE;
         master_compare_data_r <= `TCF_RST_BYTE;
         ctrl_r <= `TCF_RST_BYTE;
         toggle_on_overflow_r <= `TCF_RST_BYTE;
         action_r <= 16'h0000;
         output_pin_disconnect_r <= `TCF_RST_BYTE;
         irq_mask_r <= 9'h000;
         presc_r <= `TCF_RST_PRESC;
         for (j = 0; j < 8; j = j + 1)
            channel_compare_value_r[j] <= 16'h0000;
      end
      else if (wr_ok)
      begin
         case (ap_idx_r)
            `TCF_IDX_SELECT: capture_compare_select_r <= wb; // RL12
            `TCF_IDX_MMASK: master_compare_mask_r <= wb;
            `TCF_IDX_MDATA: master_compare_data_r <= wb;
            `TCF_IDX_CTRL: ctrl_r <= wb;
            `TCF_IDX_TOV: toggle_on_overflow_r <= wb;
            `TCF_IDX_ACTH: action_r[15:8] <= wb;
            `TCF_IDX_ACTL: action_r[7:0] <= wb;
            `TCF_IDX_DISC: output_pin_disconnect_r <= wb;
            `TCF_IDX_IRQ_MASK: irq_mask_r <= hwdata[8:0];
            `TCF_IDX_PRESC: presc_r <= wb;
            default:
            begin
               if (is_cmpv(ap_idx_r))
                  channel_compare_value_r[ap_idx_r[2:0]] <=
                     hwdata[15:0];
            end
         endcase
      end
   end

   // force bits act for one cycle and never stay set
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         force_bit_r <= `TCF_RST_BYTE;
      else if (wr_hit(wr_ok, ap_idx_r, `TCF_IDX_FORCE))
         force_bit_r <= wb; // RL2 RL14
      else
         force_bit_r <= 8'h00; // RL1
   end

   // main counter: counts on ticks, byte loads only in test mode
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         main_counter_r <= `TCF_RST_CNT;
      else if (ctrl_r[`TCF_CTRL_TEST] &&
         wr_hit(wr_ok, ap_idx_r, `TCF_IDX_CNTH))
         main_counter_r <= {wb, main_counter_r[7:0]}; // RL10
      else if (ctrl_r[`TCF_CTRL_TEST] &&
         wr_hit(wr_ok, ap_idx_r, `TCF_IDX_CNTL))
         main_counter_r <= {main_counter_r[15:8], wb}; // RL10
      else
         main_counter_r <= cnt_nxt; // RL8 RL11 RL13
   end

   // event flags and the interrupt line
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_stat_r <= 9'h000;
         irq <= 1'b0;
      end
      else
      begin
         irq_stat_r <= stat_nxt; // RL3
         irq <= |(stat_nxt & irq_mask_r);
      end
   end

   // compare pins and their output enables
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         compare_pins <= 8'h00;
         compare_pins_oe <= 8'h00;
      end
      else
      begin
         compare_pins <= pins_nxt; // RL4 RL6
         compare_pins_oe <= capture_compare_select_r &
            ~output_pin_disconnect_r; // RL7 RL12
      end
   end
endmodule // tcf_timer

// *** bench/tcf_timer_monitor.sv ***
// Purpose: port-level checks for tcf_timer
// Assumes: one hclk domain, zero-wait bus
// Notes: bound to every tcf_timer instance
`timescale 1ns/1ns
`include "tcf_defs.vh"
module tcf_timer_monitor
(
   // clock and reset
   input logic hclk,
   input logic hresetn,
   // bus
   input logic hsel,
   input logic [31:0] haddr,
   input logic [1:0] htrans,
   input logic hwrite,
   input logic hready,
   input logic [31:0] hrdata,
   input logic hreadyout,
   input logic hresp,
   // pins and interrupt
   input logic [7:0] compare_pins,
   input logic [7:0] compare_pins_oe,
   input logic irq
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic take;
   logic rd_take;
   logic [2:0] age_r;
   assign take = hsel && htrans[1] && hready;
   assign rd_take = take && !hwrite;
   // cycles since the last write was taken, saturating
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         age_r <= 3'h7;
      else if (take && hwrite)
         age_r <= 3'h0;
      else if (age_r != 3'h7)
         age_r <= age_r + 3'h1;
   end
   resp_okay_a: assert property (hresp == 1'b0)
      else $error("slave response not okay");
   zero_wait_a: assert property (take |=> hreadyout)
      else $error("data phase stretched");
   ready_start_a: assert property ($rose(hresetn) |-> hreadyout [*3])
      else $error("not ready after reset");
   force_read_zero_a: assert property (rd_take
      && haddr[9:2] == `TCF_IDX_FORCE |-> ##1 hrdata == 32'h0)
      else $error("force register read not zero");
   byte_lane_a: assert property (rd_take |-> ##1 hrdata[31:8] == 24'h0)
      else $error("read data above byte lane");
   unmapped_zero_a: assert property (rd_take && haddr[9:2] == 8'h20
      |-> ##1 hrdata == 32'h0)
      else $error("unmapped read not zero");
   oe_after_write_a: assert property (!$stable(compare_pins_oe)
      |-> age_r <= 3'h5)
      else $error("output enable moved without a write");
   reset_quiet_a: assert property ($rose(hresetn)
      |-> !irq && compare_pins == 8'h00)
      else $error("pins or irq active after reset");
   force_c: cover property (take && hwrite && haddr[9:2] == `TCF_IDX_FORCE);
   irq_c: cover property ($rose(irq));
   oe_c: cover property (!$stable(compare_pins_oe));
endmodule // tcf_timer_monitor

bind tcf_timer tcf_timer_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .compare_pins(compare_pins), .compare_pins_oe(compare_pins_oe), .irq(irq));

// *** bench/tcf_pin_load.sv ***
// Purpose: external load on the compare pins
// Assumes: each pin has a pull-down
// Notes: a released pin reads low on the wire
`timescale 1ns/1ns
module tcf_pin_load
(
   // pins from the timer
   input logic [7:0] compare_pins,
   input logic [7:0] compare_pins_oe,
   // level seen on the wire
   output logic [7:0] pin_wire
);
   assign pin_wire = compare_pins & compare_pins_oe;
endmodule // tcf_pin_load

// *** bench/tcf_timer_tb_top.sv ***
// Purpose: directed bench for tcf_timer
// Assumes: zero-wait slave, counter parked unless enabled
// Notes: byte address is four times the index
`timescale 1ns/1ns
`include "tcf_defs.vh"
module tcf_timer_tb_top;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] pins, oe, pw, a;
   int fail_count, n_tests, cyc;
   tcf_timer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .compare_pins(pins),
      .compare_pins_oe(oe), .irq(irq));
   tcf_pin_load u_load (.compare_pins(pins), .compare_pins_oe(oe),
      .pin_wire(pw));
   initial
   begin
      hclk = 0;
      forever #4 hclk = ~hclk;
   end
   task automatic check(input string nm, input logic [31:0] s, e);
      n_tests++;
      if (s !== e)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] i, input [31:0] d);
      @(posedge hclk);
      hsel <= 1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {22'h0, i, 2'b00};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] i, input [31:0] d);
      bus(1, i, d);
   endtask
   task automatic rdc(input logic [7:0] i, input [31:0] e, input string nm);
      bus(0, i, 0);
      check(nm, rd, e);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fail_count++;
         conclude();
      end
   end
   initial
   begin
      {hresetn, hsel, haddr, htrans, hwrite, hwdata} = 0;
      hsize = 3'b010;
      repeat (20) @(posedge hclk);
      hresetn <= 1;
      rdc(`TCF_IDX_CNTH, 0, "cnt_rst");
      rdc(`TCF_IDX_FORCE, 0, "force_rd");
      $display("test reset done");
      wr(`TCF_IDX_SELECT, 32'h000000ff);
      wr(`TCF_IDX_IRQ_MASK, 32'h000001ff);
      wr(`TCF_IDX_ACTH, 32'h000000ff);
      wr(`TCF_IDX_ACTL, 32'h000000ff);
      wr(`TCF_IDX_FORCE, 32'h000000ff);
      wt(3);
      check("pins_set", pins, 32'h000000ff);
      check("irq_force", irq, 32'h00000000);
      wr(`TCF_IDX_ACTL, 32'h000000aa);
      wr(`TCF_IDX_FORCE, 32'h0000000f);
      wt(3);
      check("pins_clr", pins, 32'h000000f0);
      wr(`TCF_IDX_ACTL, 32'h00000055);
      wr(`TCF_IDX_FORCE, 32'h00000005);
      wt(3);
      check("pins_tgl", pins, 32'h000000f5);
      rdc(`TCF_IDX_FORCE, 0, "force_rd2");
      $display("test force done");
      wr(`TCF_IDX_DISC, 32'h00000001);
      wt(3);
      check("oe_disc", oe, 32'h000000fe);
      wr(`TCF_IDX_SELECT, 32'h0000007f);
      wt(3);
      check("oe_sel", oe, 32'h0000007e);
      wr(`TCF_IDX_SELECT, 32'h000000ff);
      rdc(`TCF_IDX_SELECT, 32'h000000ff, "select_rd");
      $display("test select done");
      wr(`TCF_IDX_CNTH, 32'h00000012);
      rdc(`TCF_IDX_CNTH, 0, "cnt_nowr");
      wr(`TCF_IDX_CTRL, 32'h00000001);
      wr(`TCF_IDX_CNTH, 32'h000000ff);
      wr(`TCF_IDX_CNTL, 32'h000000f0);
      rdc(`TCF_IDX_CNTH, 32'h000000ff, "cnt_ld_hi");
      rdc(`TCF_IDX_CNTL, 32'h000000f0, "cnt_ld_lo");
      wr(`TCF_IDX_MMASK, 32'h0000000f);
      wr(`TCF_IDX_MDATA, 32'h0000000a);
      rdc(`TCF_IDX_MMASK, 32'h0000000f, "mmask_rd");
      rdc(`TCF_IDX_MDATA, 32'h0000000a, "mdata_rd");
      wr(`TCF_IDX_TOV, 32'h00000080);
      wr(`TCF_IDX_CTRL, 32'h00000080);
      bus(0, `TCF_IDX_CNTL, 0);
      a = rd[7:0];
      bus(0, `TCF_IDX_CNTL, 0);
      check("cnt_up", {31'h0, rd[7:0] > a}, 32'h00000001);
      wt(30);
      wr(`TCF_IDX_CTRL, 32'h00000000);
      rdc(`TCF_IDX_CNTH, 0, "cnt_wrap");
      check("pins_m7", pw, 32'h000000fa);
      check("irq_hit", irq, 32'h00000001);
      wr(`TCF_IDX_IRQ_MASK, 0);
      wt(2);
      check("irq_mask", irq, 32'h00000000);
      wr(`TCF_IDX_IRQ_MASK, 32'h000001ff);
      wt(2);
      check("irq_unmask", irq, 32'h00000001);
      wr(`TCF_IDX_IRQ_STAT, 32'h000001ff);
      wt(2);
      check("irq_clr", irq, 32'h00000000);
      rdc(8'h20, 0, "unmapped");
      $display("test counter done");
      conclude();
   end
endmodule // tcf_timer_tb_top
